// ---- inc/ppc_pkg.sv ----
package ppc_pkg;
  localparam int unsigned NUM_PINS  = 6;
  localparam int unsigned NUM_BIDIR = 4;
  localparam int unsigned PIN_IN    = 5;  // Input-only pin
  localparam int unsigned PIN_OUT   = 4;  // Output-only pin
  localparam int unsigned ADDR_W    = 4;
  localparam int unsigned DATA_W    = 8;
  // Register offsets
  localparam logic [3:0] OFS_DATA    = 4'h0;
  localparam logic [3:0] OFS_DIR     = 4'h1;
  localparam logic [3:0] OFS_PULLUP  = 4'h2;
  localparam logic [3:0] OFS_SLEW    = 4'h3;
  localparam logic [3:0] OFS_DRIVE   = 4'h4;
  localparam logic [3:0] OFS_SYSOPT  = 4'h5;
  localparam logic [3:0] OFS_PINS    = 4'h6;
  localparam logic [3:0] OFS_PULLDIR = 4'h7;
  // System option fields
  localparam int unsigned SYS_DBG_BIT = 0;
  localparam int unsigned SYS_RST_BIT = 1;
  // Reset values
  localparam logic [5:0] RST_DATA   = 6'h00;
  localparam logic [5:0] RST_DIR    = 6'h00;
  localparam logic [5:0] RST_PULLUP = 6'h00;
  localparam logic [5:0] RST_SLEW   = 6'h10;
  localparam logic [5:0] RST_DRIVE  = 6'h00;
  localparam logic [1:0] RST_SYSOPT = 2'h1;
  typedef enum logic [1:0] {
    PPC_OWN_PORT = 2'h0,
    PPC_OWN_ALT1 = 2'h1,
    PPC_OWN_ALT2 = 2'h3,
    PPC_OWN_ALT3 = 2'h2
  } ppc_owner_e;
endpackage

// ---- logic/ppc_pad_cell.sv ----
module ppc_pad_cell
  import ppc_pkg::*;
(
  input  wire logic drive_in,     // Pin driven as output
  input  wire logic pull_en_in,   // Pullup enable bit
  input  wire logic force_pu_in,  // Forced pullup
  input  wire logic analog_in,    // Analog owns pin
  input  wire logic rise_in,      // Rising-edge detector owns pin
  input  wire logic slew_in,      // Slew enable bit
  input  wire logic hdrv_in,      // High drive bit
  output logic      pu_out,       // Pullup on
  output logic      pd_out,       // Pulldown on
  output logic      slew_out,     // Effective slew
  output logic      hdrv_out      // Effective high drive
);
  logic pull_on;
  // Output or analog kills the pull device
  assign pull_on  = (pull_en_in | force_pu_in) & ~drive_in & ~analog_in;
  assign pu_out   = pull_on & (~rise_in | force_pu_in);
  assign pd_out   = pull_on & rise_in & ~force_pu_in;
  assign slew_out = slew_in & drive_in;
  assign hdrv_out = hdrv_in & drive_in;
endmodule

// ---- logic/ppc_port.sv ----
// Operation
// - Six pins: four bidirectional, one input-only, one output-only, all shared.
// - Output pins get software drive strength and slew limit selection.
// - Input pins get a software pullup enable.
// - Reset makes non-output-only pins floating inputs, pullups off.
// - Reset disables output-only port function; low drive, slew limited.
// - After any reset pin four takes the debug/mode function.
// - Pad bits are separate registers, per pin, independent of data/direction.
// - Per-pin pullup bit turns the pullup on unless overridden.
// - Pullup forced off while pin drives as output.
// - Pullup forced off while analog function owns pin.
// - Keyboard or interrupt rising-edge owner turns pull into pulldown.
// - Per-pin slew bit limits output transition rate.
// - Slew bit has no effect on input pins.
// - Per-pin drive bit: set high drive, clear low drive.
// - Fixed owner priority per pin, port lowest.
// - Two analog modules on one pin both connect.
// - Debug function enabled forces pin four pullup on while debug is not driving the pin.
module ppc_port
  import ppc_pkg::*;
(
  input  wire logic              clk_in,          // Bus clock
  input  wire logic              nrst_in,         // Async reset, active low
  input  wire logic [ADDR_W-1:0] addr_in,         // Register address
  input  wire logic [DATA_W-1:0] wdata_in,        // Write data
  input  wire logic              wr_in,           // Write strobe
  input  wire logic              rd_in,           // Read strobe
  output logic      [DATA_W-1:0] rdata_out,       // Read data
  input  wire logic [5:0]        pin_in,          // Pad input levels
  output logic      [5:0]        pin_out,         // Pad output levels
  output logic      [5:0]        pin_oe_n_out,    // Pad enable, low drives
  output logic      [5:0]        pullup_out,      // Pullup on
  output logic      [5:0]        pulldown_out,    // Pulldown on
  output logic      [5:0]        slew_out,        // Slew limit on
  output logic      [5:0]        hdrv_out,        // High drive on
  input  wire logic [3:0]        kbd_en_in,       // Keyboard owns pins 0-3
  input  wire logic [3:0]        kbd_rise_in,     // Keyboard rising edge
  input  wire logic [3:0]        tmr1_en_in,      // Timer1 channel/clock owns pins
  input  wire logic [3:0]        tmr1_oe_in,      // Timer1 channel is output
  input  wire logic [3:0]        tmr1_o_in,       // Timer1 channel output level
  input  wire logic [3:0]        adc_en_in,       // Converter owns pins 0-3
  input  wire logic [3:0]        cmp_en_in,       // Second analog module on pins
  output logic      [3:0]        analog_conn_out, // Analog switch closed
  input  wire logic              tmr2_o_en_in,    // Timer2 output owns pin 4
  input  wire logic              tmr2_o_in,       // Timer2 output level
  input  wire logic              tmr2_cap_en_in,  // Timer2 capture owns pin 5
  input  wire logic              irq_en_in,       // Interrupt owns pin 5
  input  wire logic              irq_rise_in,     // Interrupt rising edge
  input  wire logic              dbg_o_in,        // Debug pin drive level
  input  wire logic              dbg_oe_in,       // Debug pin actively driven
  output logic                   dbg_pin_en_out,  // Debug/mode owns pin 4
  output logic                   reset_pin_out,   // Reset owns pin 5
  output logic      [5:0]        pin_sync_out     // Synchronised pin levels
);
  logic [5:0] port_data;
  logic [5:0] port_dir;
  logic [5:0] pad_pullup_enable_bit;
  logic [5:0] pad_slew_limit_enable_bit;
  logic [5:0] pad_high_drive_select_bit;
  logic       debug_pin_function_enable;
  logic       reset_pin_enable;
  logic [5:0] sync_a;
  logic [5:0] sync_b;
  ppc_owner_e owner [NUM_PINS];
  logic [5:0] next_o;
  logic [5:0] next_drv;
  logic [5:0] analog;
  logic [5:0] rise;
  logic [5:0] force_pu;
  logic [5:0] pu_c;
  logic [5:0] pd_c;
  logic [5:0] sl_c;
  logic [5:0] hd_c;

  // Pad bits live apart from data and direction
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pad_pullup_enable_bit     <= RST_PULLUP;
      pad_slew_limit_enable_bit <= RST_SLEW;
      pad_high_drive_select_bit <= RST_DRIVE;
    end else if (wr_in) begin
      unique case (addr_in)
        OFS_PULLUP: pad_pullup_enable_bit     <= wdata_in[5:0];
        OFS_SLEW:   pad_slew_limit_enable_bit <= wdata_in[5:0];
        OFS_DRIVE:  pad_high_drive_select_bit <= wdata_in[5:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      port_data <= RST_DATA;
      port_dir  <= RST_DIR;
    end else if (wr_in) begin
      if (addr_in == OFS_DATA) begin
        port_data <= wdata_in[5:0];
      end
      if (addr_in == OFS_DIR) begin
        // Input-only pin has no driver; output-only pin may be enabled
        port_dir <= wdata_in[5:0] & ~(6'h01 << PIN_IN);
      end
    end
  end

  // Reset-pin select is sticky until the next reset
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      debug_pin_function_enable <= RST_SYSOPT[SYS_DBG_BIT];
      reset_pin_enable          <= RST_SYSOPT[SYS_RST_BIT];
    end else if (wr_in && addr_in == OFS_SYSOPT) begin
      debug_pin_function_enable <= wdata_in[SYS_DBG_BIT];
      reset_pin_enable          <= reset_pin_enable | wdata_in[SYS_RST_BIT];
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync_a <= 6'h00;
      sync_b <= 6'h00;
    end else begin
      sync_a <= pin_in;
      sync_b <= sync_a;
    end
  end

  // Ownership by fixed priority, highest wins
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      owner[i] = PPC_OWN_PORT;
    end
    for (int i = 0; i < NUM_BIDIR; i++) begin
      if (adc_en_in[i] || cmp_en_in[i]) begin
        owner[i] = PPC_OWN_ALT3;
      end else if (tmr1_en_in[i]) begin
        owner[i] = PPC_OWN_ALT2;
      end else if (kbd_en_in[i]) begin
        owner[i] = PPC_OWN_ALT1;
      end
    end
    if (debug_pin_function_enable) begin
      owner[PIN_OUT] = PPC_OWN_ALT2;
    end else if (tmr2_o_en_in) begin
      owner[PIN_OUT] = PPC_OWN_ALT1;
    end
    if (reset_pin_enable) begin
      owner[PIN_IN] = PPC_OWN_ALT3;
    end else if (irq_en_in) begin
      owner[PIN_IN] = PPC_OWN_ALT2;
    end else if (tmr2_cap_en_in) begin
      owner[PIN_IN] = PPC_OWN_ALT1;
    end
  end

  always_comb begin
    next_o   = port_data;
    next_drv = port_dir;
    analog   = 6'h00;
    rise     = 6'h00;
    force_pu = 6'h00;
    for (int i = 0; i < NUM_BIDIR; i++) begin
      unique case (owner[i])
        PPC_OWN_PORT: begin
        end
        PPC_OWN_ALT1: begin
          next_drv[i] = 1'b0;
          rise[i]     = kbd_rise_in[i];
        end
        PPC_OWN_ALT2: begin
          next_drv[i] = tmr1_oe_in[i];
          next_o[i]   = tmr1_o_in[i];
        end
        PPC_OWN_ALT3: begin
          next_drv[i] = 1'b0;
          analog[i]   = 1'b1;
        end
      endcase
    end
    unique case (owner[PIN_OUT])
      PPC_OWN_ALT2: begin
        next_drv[PIN_OUT] = dbg_oe_in;
        next_o[PIN_OUT]   = dbg_o_in;
        force_pu[PIN_OUT] = 1'b1;
      end
      PPC_OWN_ALT1: begin
        next_drv[PIN_OUT] = 1'b1;
        next_o[PIN_OUT]   = tmr2_o_in;
      end
      default: begin
      end
    endcase
    // Pin five never drives
    next_drv[PIN_IN] = 1'b0;
    next_o[PIN_IN]   = 1'b0;
    unique case (owner[PIN_IN])
      PPC_OWN_ALT3: force_pu[PIN_IN] = 1'b1;
      PPC_OWN_ALT2: rise[PIN_IN]     = irq_rise_in;
      default: begin
      end
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_pad
      ppc_pad_cell u_pad (
        .drive_in   (next_drv[g]),
        .pull_en_in (pad_pullup_enable_bit[g]),
        .force_pu_in(force_pu[g]),
        .analog_in  (analog[g]),
        .rise_in    (rise[g]),
        .slew_in    (pad_slew_limit_enable_bit[g]),
        .hdrv_in    (pad_high_drive_select_bit[g]),
        .pu_out     (pu_c[g]),
        .pd_out     (pd_c[g]),
        .slew_out   (sl_c[g]),
        .hdrv_out   (hd_c[g])
      );
    end
  endgenerate

  // Registered pads; one cycle latency keeps outputs glitch free
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_out         <= 6'h00;
      pin_oe_n_out    <= 6'h3F;
      pullup_out      <= 6'h00;
      pulldown_out    <= 6'h00;
      slew_out        <= 6'h00;
      hdrv_out        <= 6'h00;
      analog_conn_out <= 4'h0;
      dbg_pin_en_out  <= 1'b1;
      reset_pin_out   <= 1'b0;
      pin_sync_out    <= 6'h00;
    end else begin
      pin_out         <= next_o;
      pin_oe_n_out    <= ~next_drv;
      pullup_out      <= pu_c;
      pulldown_out    <= pd_c;
      slew_out        <= sl_c;
      hdrv_out        <= hd_c;
      // Both analog modules share the switch; no arbitration
      analog_conn_out <= adc_en_in | cmp_en_in;
      dbg_pin_en_out  <= debug_pin_function_enable;
      reset_pin_out   <= reset_pin_enable;
      pin_sync_out    <= sync_b;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      unique case (addr_in)
        OFS_DATA:    rdata_out <= {2'h0, port_data};
        OFS_DIR:     rdata_out <= {2'h0, port_dir};
        OFS_PULLUP:  rdata_out <= {2'h0, pad_pullup_enable_bit};
        OFS_SLEW:    rdata_out <= {2'h0, pad_slew_limit_enable_bit};
        OFS_DRIVE:   rdata_out <= {2'h0, pad_high_drive_select_bit};
        OFS_SYSOPT:  rdata_out <= {6'h00, reset_pin_enable, debug_pin_function_enable};
        OFS_PINS:    rdata_out <= {2'h0, sync_b};
        OFS_PULLDIR: rdata_out <= {2'h0, pd_c};
        default:     rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  a_pull_off_drive: assert property (@(posedge clk_in) disable iff (!nrst_in)
    1'b1 |=> ((pullup_out | pulldown_out) & ~pin_oe_n_out) == 6'h00)
    else $error("pull device on while driving");
  a_slew_input: assert property (@(posedge clk_in) disable iff (!nrst_in)
    1'b1 |=> (slew_out & pin_oe_n_out) == 6'h00)
    else $error("slew active on input pin");
  a_hdrv_follow: assert property (@(posedge clk_in) disable iff (!nrst_in)
    1'b1 |=> (hdrv_out == (~pin_oe_n_out & $past(pad_high_drive_select_bit))))
    else $error("drive strength mismatch");
  a_analog_pull: assert property (@(posedge clk_in) disable iff (!nrst_in)
    adc_en_in[2] |=> !pullup_out[2] && !pulldown_out[2] && analog_conn_out[2])
    else $error("analog pin pulled");
  // Pad outputs still show reset values on the first edge after release
  a_dbg_pullup: assert property (@(posedge clk_in) disable iff (!nrst_in)
    dbg_pin_en_out && pin_oe_n_out[PIN_OUT] && $past(nrst_in) |-> pullup_out[PIN_OUT])
    else $error("debug pin pullup missing");
  a_in_only: assert property (@(posedge clk_in) disable iff (!nrst_in)
    pin_oe_n_out[PIN_IN])
    else $error("input-only pin driven");
  a_both_analog: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (adc_en_in[2] && cmp_en_in[2]) |=> analog_conn_out[2])
    else $error("analog modules not both connected");
  a_kbd_pulldown: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (owner[1] == PPC_OWN_ALT1 && kbd_rise_in[1] && pad_pullup_enable_bit[1])
    |=> pulldown_out[1] && !pullup_out[1])
    else $error("rising edge pull not pulldown");
  a_reset_sticky: assert property (@(posedge clk_in) disable iff (!nrst_in)
    reset_pin_out |=> reset_pin_out)
    else $error("reset pin function dropped");
  a_sysopt_write: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (wr_in && addr_in == OFS_SYSOPT) |=> ##1 dbg_pin_en_out == $past(wdata_in[SYS_DBG_BIT], 2))
    else $error("debug enable not updated");
endmodule

// ---- tb/ppc_pads.sv ----
module ppc_pads (
  input  wire logic       clk_in,     // Core clock
  input  wire logic [5:0] drv_in,     // Levels driven by the port
  input  wire logic [5:0] oe_n_in,    // Low where the port drives
  input  wire logic [5:0] pu_in,      // Pullup on
  input  wire logic [5:0] pd_in,      // Pulldown on
  input  wire logic [5:0] ext_in,     // Board drive level
  input  wire logic [5:0] ext_en_in,  // Board drives pin
  output logic      [5:0] lvl_out     // Resolved pad level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] flt = 6'h15;
  // Floating pads wander so an unpulled input never reads steady
  always @(posedge clk_in) flt <= ~flt;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (!oe_n_in[i]) lvl_out[i] = drv_in[i];
      else if (ext_en_in[i]) lvl_out[i] = ext_in[i];
      else if (pu_in[i]) lvl_out[i] = 1'b1;
      else if (pd_in[i]) lvl_out[i] = 1'b0;
      else lvl_out[i] = flt[i];
    end
  end
endmodule

// ---- tb/tb.sv ----
module tb import ppc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [3:0] sel; logic [7:0] exp;} ppc_note_s;
  logic clk_in = 1'b0, nrst_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, smp = 1'b0, rd_d = 1'b0;
  logic [3:0] addr_in = 4'h0, kbd_en = 4'h0, kbd_rise = 4'h0, t1_en = 4'h0, t1_oe = 4'h0;
  logic [3:0] t1_o = 4'h0, adc_en = 4'h0, cmp_en = 4'h0, aconn;
  logic [7:0] wdata_in = 8'h00, rdata_out, got;
  logic t2_en = 1'b0, t2_o = 1'b0, cap_en = 1'b0, irq_en = 1'b0, irq_rise = 1'b0;
  logic dbg_o = 1'b0, dbg_oe = 1'b0, dbg_en, rst_pin;
  logic [5:0] pin_out, oe_n, pu, pd, slew, hdrv, lvl, dv, pv, sv, hv, psync;
  logic [31:0] seed = 32'h69EF;
  int n_fail = 0, samples_checked = 0, cyc = 0;
  ppc_note_s notes[$];
  ppc_note_s cur;
  logic [3:0] ra[7] = '{OFS_DATA, OFS_DIR, OFS_PULLUP, OFS_SLEW, OFS_DRIVE, OFS_SYSOPT, 4'h8};
  logic [7:0] re[7] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h01, 8'h00};
  string nm[10] = '{"read data", "pullup", "pulldown", "slew", "drive", "output enable",
                    "driven level", "analog switch", "pin owner flags", "synced pins"};

  always #2.5 clk_in = ~clk_in;

  ppc_port u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pin_in(lvl), .pin_out(pin_out),
    .pin_oe_n_out(oe_n), .pullup_out(pu), .pulldown_out(pd), .slew_out(slew), .hdrv_out(hdrv),
    .kbd_en_in(kbd_en), .kbd_rise_in(kbd_rise), .tmr1_en_in(t1_en), .tmr1_oe_in(t1_oe),
    .tmr1_o_in(t1_o), .adc_en_in(adc_en), .cmp_en_in(cmp_en), .analog_conn_out(aconn),
    .tmr2_o_en_in(t2_en), .tmr2_o_in(t2_o), .tmr2_cap_en_in(cap_en), .irq_en_in(irq_en),
    .irq_rise_in(irq_rise), .dbg_o_in(dbg_o), .dbg_oe_in(dbg_oe), .dbg_pin_en_out(dbg_en),
    .reset_pin_out(rst_pin), .pin_sync_out(psync));

  ppc_pads u_pads (.clk_in(clk_in), .drv_in(pin_out), .oe_n_in(oe_n), .pu_in(pu), .pd_in(pd),
    .ext_in(6'h20), .ext_en_in(6'h20), .lvl_out(lvl));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] pick(input logic [3:0] s);
    case (s)
      4'h0: return rdata_out;
      4'h1: return {2'b00, pu};
      4'h2: return {2'b00, pd};
      4'h3: return {2'b00, slew};
      4'h4: return {2'b00, hdrv};
      4'h5: return {2'b00, oe_n};
      4'h6: return {2'b00, pin_out & ~oe_n};
      4'h7: return {4'h0, aconn};
      4'h9: return {2'b00, psync};
      default: return {6'h00, rst_pin, dbg_en};
    endcase
  endfunction

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    notes.push_back('{4'h0, e});
    @(posedge clk_in);
    rd_in <= 1'b0;
  endtask

  // Extra settle edges cover the register-to-pad pipeline
  task automatic chk(input logic [3:0] s, input logic [7:0] e);
    repeat (3) @(posedge clk_in);
    notes.push_back('{s, e});
    smp <= 1'b1;
    @(posedge clk_in);
    smp <= 1'b0;
  endtask

  task automatic conclude;
    $display("Comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk_in) begin
    if (rd_d || smp) begin
      cur = notes.pop_front();
      got = pick(cur.sel);
      samples_checked++;
      if (got !== cur.exp) begin
        n_fail++;
        $display("Error %s expected %h seen %h", nm[cur.sel], cur.exp, got);
      end
    end
    rd_d <= rd_in;
  end

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end

  initial begin
    repeat (8) @(posedge clk_in);
    nrst_in <= 1'b1;
    chk(4'h5, 8'h3F);
    chk(4'h1, 8'h10);
    chk(4'h2, 8'h00);
    chk(4'h3, 8'h00);
    chk(4'h4, 8'h00);
    chk(4'h8, 8'h01);
    wr(4'hF, 8'hFF);
    foreach (ra[i]) rd(ra[i], re[i]);
    wr(OFS_SYSOPT, 8'h00);
    chk(4'h8, 8'h00);
    repeat (4) begin
      seed = lfsr(lfsr(seed));
      dv = seed[5:0];
      pv = seed[11:6] & 6'h2F;
      sv = seed[17:12];
      hv = seed[23:18];
      wr(OFS_DATA, {2'b00, seed[29:24]});
      wr(OFS_DIR, {2'b00, dv});
      wr(OFS_PULLUP, {2'b00, pv});
      wr(OFS_SLEW, {2'b00, sv});
      wr(OFS_DRIVE, {2'b00, hv});
      rd(OFS_DIR, {3'b000, dv[4:0]});
      rd(OFS_DRIVE, {2'b00, hv});
      chk(4'h5, {2'b00, ~(dv & 6'h1F)});
      chk(4'h1, {2'b00, pv & ~(dv & 6'h1F)});
      chk(4'h3, {2'b00, sv & dv & 6'h1F});
      chk(4'h4, {2'b00, hv & dv & 6'h1F});
      chk(4'h6, {2'b00, seed[29:24] & dv & 6'h1F});
    end
    wr(OFS_DIR, 8'h02);
    wr(OFS_PULLUP, 8'h2F);
    wr(OFS_SLEW, 8'h01);
    wr(OFS_DRIVE, 8'h01);
    @(posedge clk_in);
    {t1_en, t1_oe, t1_o} <= {4'h1, 4'h1, 4'h1};
    {kbd_en, kbd_rise, adc_en, cmp_en} <= {4'hA, 4'hA, 4'hC, 4'h4};
    {irq_en, irq_rise, cap_en} <= 3'b111;
    chk(4'h5, 8'h3E);
    chk(4'h6, 8'h01);
    chk(4'h1, 8'h00);
    chk(4'h2, 8'h22);
    rd(OFS_PULLDIR, 8'h22);
    chk(4'h7, 8'h0C);
    chk(4'h3, 8'h01);
    chk(4'h4, 8'h01);
    @(posedge clk_in);
    {t1_en, t1_oe, t1_o, kbd_en, kbd_rise, adc_en, cmp_en} <= 28'h0;
    {irq_en, irq_rise, cap_en, t2_en, t2_o} <= 5'b00011;
    wr(OFS_DIR, 8'h10);
    wr(OFS_DATA, 8'h00);
    chk(4'h6, 8'h10);
    wr(OFS_SYSOPT, 8'h01);
    chk(4'h5, 8'h3F);
    chk(4'h1, 8'h3F);
    @(posedge clk_in);
    {dbg_oe, dbg_o} <= 2'b10;
    chk(4'h5, 8'h2F);
    chk(4'h6, 8'h00);
    @(posedge clk_in);
    {dbg_oe, t2_en, t2_o} <= 3'b000;
    wr(OFS_PULLUP, 8'h00);
    wr(OFS_SYSOPT, 8'h02);
    chk(4'h8, 8'h02);
    chk(4'h1, 8'h20);
    wr(OFS_SYSOPT, 8'h00);
    rd(OFS_SYSOPT, 8'h02);
    @(posedge clk_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    chk(4'h8, 8'h01);
    rd(OFS_PULLUP, 8'h00);
    wr(OFS_PULLUP, 8'h2F);
    chk(4'h1, 8'h3F);
    rd(OFS_PINS, 8'h3F);
    chk(4'h9, 8'h3F);
    repeat (2) @(posedge clk_in);
    conclude();
  end
endmodule
